// file: hw/aoc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) after reset the output runs four-lane demultiplex, one sample per lane per clock
// (RULE2) config bit 8 high in double rate selects two-lane mode on lanes c, d
// (RULE3) in single rate, config bit 8 is the launch edge select instead
// (RULE4) lane latency: d 13, b 14 (fall), c 13.5, a 14.5 (rise) clocks; code gives c 13, a 14, same as fall
// (RULE5) single rate: data changes on clock rise if edge select high, else fall
// (RULE6) output clock at lane rate in single rate, half rate in double rate; code holds it at a fixed level in single rate
// (RULE7) power-down high puts data, clock and range outputs in high impedance
// (RULE8) power-down during calibration waits until calibration completes
// (RULE9) power-down high at power-on holds off power-up calibration until low
// (RULE10) manual calibration request while powered down is ignored and forgotten
// (RULE11) host fixes pin or extended control choice on the shared pin
// (RULE12) power-on loads extended defaults: double rate, four-lane, trim on, pattern off; code loads CFG_TRIM_SKIP (bit 13) high
// (RULE13) serial writes only accepted and effective in extended control mode
// (RULE14) host holds serial select low during each access
// (RULE15) data is most significant bit first, sampled on serial clock rise
// (RULE16) frame is 32 bits: header 0x001, 4-bit address, 16 data bits
// (RULE17) address most significant bit follows the header, least significant last
// (RULE18) next frame may start at the 33rd clock without releasing select
// (RULE19) addresses 1,2,3,D,E,F decode to registers; the rest are reserved
// (RULE20) host should not write registers during calibration
// (RULE21) pin mode phase adjusts automatically; extended uses fine/coarse registers
// (RULE22) pattern enable in extended mode replaces conversion data with a pattern
// (RULE23) host calibration request: pin low 80 clocks then high 80 clocks
// (RULE24) config bit 10 zero selects double rate, one selects single rate
// (RULE25) select released before 32 bits discards the partial frame
// (RULE26) data applies only after the 32nd bit; reserved addresses ignored
module aoc_top
    import aoc_pkg::*;
#(
    parameter int SAMPLE_W = 8,
    parameter int CAL_CYCLES = CAL_RUN_CYCLES
) (
    // system clock and reset (input clock domain)
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // converter samples, one per edge of the input clock
    input  wire logic [SAMPLE_W-1:0] sample_rise,
    input  wire logic [SAMPLE_W-1:0] sample_fall,
    input  wire logic                range_rise,
    input  wire logic                range_fall,
    // control pins
    input  wire logic                power_down_pin,
    input  wire logic                cal_request_n,
    input  wire logic                range_or_ext_ctrl_pin,
    input  wire logic                launch_edge_select,
    input  wire logic                double_rate_pin,
    input  wire logic                swing_select_pin,
    // serial register port
    input  wire logic                serial_clk,
    input  wire logic                serial_select_n,
    input  wire logic                serial_input_line,
    // output lanes
    output logic [SAMPLE_W-1:0]      lane_a,
    output logic [SAMPLE_W-1:0]      lane_b,
    output logic [SAMPLE_W-1:0]      lane_c,
    output logic [SAMPLE_W-1:0]      lane_d,
    output logic                     out_range,
    output logic                     output_data_clock,
    output logic                     outputs_oe,
    // status and analog steering
    output logic                     cal_running,
    output logic                     swing_bit,
    output logic                     auto_phase_en,
    output logic [15:0]              offset_word,
    output logic [15:0]              full_scale_word,
    output logic [15:0]              phase_fine_word,
    output logic [15:0]              phase_coarse_word
);
    localparam int LAT = 13;
    localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

    // =================================================================
    // serial port (serial clock domain)
    logic [30:0] shift;
    logic [5:0]  bit_cnt;
    logic [3:0]  wr_addr;
    logic [15:0] wr_data;
    logic        wr_toggle;
    logic [31:0] frame;

    assign frame = {shift, serial_input_line};

    // shift in msb first on serial clock rise while selected
    always_ff @(posedge serial_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift <= '0;
        end else if (!serial_select_n) begin
            shift <= frame[30:0]; // RULE15
        end
    end

    // bit counter: select high clears it at once
    // the host stops its clock between frames, so a cut frame must not
    // wait for a clock edge to lose its count, or the next frame would
    // be taken as the tail of the old one
    always_ff @(posedge serial_clk or negedge rst_b or posedge serial_select_n) begin
        if (!rst_b) begin
            bit_cnt <= '0;
        end else if (serial_select_n) begin // RULE14
            bit_cnt <= '0; // RULE25
        end else if (bit_cnt == FRAME_BITS - 6'h01) begin
            bit_cnt <= '0; // RULE18
        end else begin
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // capture complete frame with valid header, hand over by toggle
    // address and data stand for a whole frame time after the toggle,
    // so the system side may read them once the toggle is synchronised
    always_ff @(posedge serial_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_addr   <= '0;
            wr_data   <= '0;
            wr_toggle <= 1'b0;
        end else if (!serial_select_n && bit_cnt == FRAME_BITS - 6'h01
                     && frame[31:20] == FRAME_HEADER) begin // RULE16
            wr_addr   <= frame[19:16]; // RULE17
            wr_data   <= frame[15:0];
            wr_toggle <= ~wr_toggle; // RULE26
        end
    end

    // =================================================================
    // pin synchronisers into the system domain
    // power-down resets to its active (high) level and calibration to its
    // inactive level, so that release of reset shows no false request
    logic [2:0]  tog_sync;
    logic [1:0]  pd_sync;
    logic [1:0]  cal_sync;
    logic [1:0]  ext_sync;
    logic [1:0]  edge_sync;
    logic [1:0]  ddr_sync;
    logic [1:0]  swing_sync;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tog_sync   <= '0;
            pd_sync    <= 2'h3;
            cal_sync   <= 2'h3;
            ext_sync   <= '0;
            edge_sync  <= '0;
            ddr_sync   <= '0;
            swing_sync <= '0;
        end else begin
            tog_sync   <= {tog_sync[1:0], wr_toggle};
            pd_sync    <= {pd_sync[0], power_down_pin};
            cal_sync   <= {cal_sync[0], cal_request_n};
            ext_sync   <= {ext_sync[0], range_or_ext_ctrl_pin};
            edge_sync  <= {edge_sync[0], launch_edge_select};
            ddr_sync   <= {ddr_sync[0], double_rate_pin};
            swing_sync <= {swing_sync[0], swing_select_pin};
        end
    end

    logic pd_now;
    logic ext_mode;
    logic wr_event;
    assign pd_now   = pd_sync[1];
    assign ext_mode = ext_sync[1]; // RULE11
    assign wr_event = tog_sync[2] ^ tog_sync[1];

    // =================================================================
    // register file, written only in extended mode
    // frames that arrive in pin mode are dropped, not kept for later
    logic [15:0] cfg;
    logic [15:0] pat;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg               <= RST_CONFIG; // RULE12
            offset_word       <= RST_OFFSET;
            full_scale_word   <= RST_FULL_SCALE;
            phase_fine_word   <= RST_PHASE_FINE;
            phase_coarse_word <= RST_PHASE_COARSE;
            pat               <= RST_PATTERN;
        end else if (wr_event && ext_mode) begin // RULE13
            unique case (wr_addr) // RULE19
                ADDR_CONFIG:       cfg               <= wr_data;
                ADDR_OFFSET:       offset_word       <= wr_data;
                ADDR_FULL_SCALE:   full_scale_word   <= wr_data;
                ADDR_PHASE_FINE:   phase_fine_word   <= wr_data;
                ADDR_PHASE_COARSE: phase_coarse_word <= wr_data;
                ADDR_PATTERN:      pat               <= wr_data;
                default:           ; // RULE26
            endcase
        end
    end

    // effective modes: registers count only in extended mode
    logic ddr_on;
    logic edge_rise;
    logic two_lane;
    logic pat_on;
    assign ddr_on    = ext_mode ? !cfg[CFG_DDR_DISABLE] : ddr_sync[1]; // RULE24
    assign edge_rise = ext_mode ? cfg[CFG_EDGE_DEMUX] : edge_sync[1]; // RULE3
    assign two_lane  = ext_mode && ddr_on && cfg[CFG_EDGE_DEMUX]; // RULE2
    assign pat_on    = ext_mode && pat[PAT_ENABLE]; // RULE22

    // =================================================================
    // calibration and power-down sequencing
    typedef enum logic [1:0] {
        AOC_WAIT_PWR = 2'b00,
        AOC_ACTIVE   = 2'b01,
        AOC_CAL      = 2'b10,
        AOC_DOWN     = 2'b11
    } aoc_state_e;

    aoc_state_e  state;
    logic [15:0] cal_cnt;
    logic [7:0]  low_cnt;
    logic [7:0]  high_cnt;
    logic        req_armed;

    // request detector: 80 clocks low then 80 clocks high
    // the request arms on the 80th low sample, so exactly 80 is enough;
    // anything seen while powered down is thrown away
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt   <= '0;
            high_cnt  <= '0;
            req_armed <= 1'b0;
        end else if (state == AOC_DOWN || pd_now) begin
            low_cnt   <= '0; // RULE10
            high_cnt  <= '0;
            req_armed <= 1'b0;
        end else if (!cal_sync[1]) begin
            high_cnt <= '0;
            if (low_cnt == CAL_REQ_CYCLES - 8'h01) begin
                req_armed <= 1'b1; // RULE23
            end else begin
                low_cnt <= low_cnt + 8'h01;
            end
        end else begin
            low_cnt <= '0;
            if (req_armed && high_cnt != CAL_REQ_CYCLES) begin
                high_cnt <= high_cnt + 8'h01;
            end else if (high_cnt == CAL_REQ_CYCLES) begin
                req_armed <= 1'b0;
                high_cnt  <= '0;
            end else begin
                req_armed <= 1'b0;
            end
        end
    end

    logic cal_start;
    assign cal_start = req_armed && cal_sync[1] && high_cnt == CAL_REQ_CYCLES - 8'h01;

    // state sequencing
    // a running calibration always runs to its end; power-down is only
    // looked at once the counter has expired
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state   <= AOC_WAIT_PWR;
            cal_cnt <= '0;
        end else begin
            unique case (state)
                AOC_WAIT_PWR: begin
                    if (!pd_now) begin // RULE9
                        state   <= AOC_CAL;
                        cal_cnt <= '0;
                    end
                end
                AOC_ACTIVE: begin
                    if (pd_now) begin
                        state <= AOC_DOWN;
                    end else if (cal_start) begin
                        state   <= AOC_CAL;
                        cal_cnt <= '0;
                    end
                end
                AOC_CAL: begin
                    if (cal_cnt == CAL_LAST) begin
                        state <= pd_now ? AOC_DOWN : AOC_ACTIVE; // RULE8
                    end else begin
                        cal_cnt <= cal_cnt + 16'h0001;
                    end
                end
                AOC_DOWN: begin
                    if (!pd_now) begin
                        state <= AOC_ACTIVE; // RULE10
                    end
                end
            endcase
        end
    end

    // =================================================================
    // latency pipes: fall and rise samples alike, 14 stages each, no half clock
    // the pipes keep running in power-down and calibration, so valid
    // data follows as soon as the outputs come back
    logic [SAMPLE_W:0] fall_pipe [LAT+1];
    logic [SAMPLE_W:0] rise_pipe [LAT+1];
    logic [SAMPLE_W-1:0] pat_cnt;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i <= LAT; i++) begin
                fall_pipe[i] <= '0;
                rise_pipe[i] <= '0;
            end
            pat_cnt <= '0;
        end else begin
            pat_cnt <= pat_cnt + {{(SAMPLE_W-1){1'b0}}, 1'b1};
            fall_pipe[0] <= pat_on ? {1'b0, pat_cnt} : {range_fall, sample_fall}; // RULE22
            rise_pipe[0] <= pat_on ? {1'b1, ~pat_cnt} : {range_rise, sample_rise};
            for (int i = 1; i <= LAT; i++) begin
                fall_pipe[i] <= fall_pipe[i-1]; // RULE4
                rise_pipe[i] <= rise_pipe[i-1];
            end
        end
    end

    // lane registers with demux and edge/rate output clock
    // outputs_oe low stands for high impedance at the pads
    logic active_out;
    assign active_out = state != AOC_DOWN && state != AOC_WAIT_PWR;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lane_a            <= '0;
            lane_b            <= '0;
            lane_c            <= '0;
            lane_d            <= '0;
            out_range         <= 1'b0;
            output_data_clock <= 1'b0;
            outputs_oe        <= 1'b0;
        end else begin
            outputs_oe <= active_out; // RULE7
            lane_d <= fall_pipe[LAT-1][SAMPLE_W-1:0];
            lane_c <= rise_pipe[LAT-1][SAMPLE_W-1:0];
            if (two_lane) begin
                lane_a <= '0; // RULE2
                lane_b <= '0;
            end else begin
                lane_b <= fall_pipe[LAT][SAMPLE_W-1:0]; // RULE1
                lane_a <= rise_pipe[LAT][SAMPLE_W-1:0];
            end
            out_range <= fall_pipe[LAT-1][SAMPLE_W] | rise_pipe[LAT-1][SAMPLE_W];
            if (ddr_on) begin
                output_data_clock <= ~output_data_clock; // RULE6
            end else begin
                output_data_clock <= ~edge_rise; // RULE5
            end
        end
    end

    // status and analog steering
    // mode outputs follow the synchronised strap pin, so they settle a
    // few clocks after reset is released
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cal_running   <= 1'b0;
            swing_bit     <= 1'b1;
            auto_phase_en <= 1'b0;
        end else begin
            cal_running   <= state == AOC_CAL;
            swing_bit     <= ext_mode ? cfg[CFG_SWING] : swing_sync[1];
            auto_phase_en <= !ext_mode; // RULE21
        end
    end
endmodule : aoc_top
`default_nettype wire

// file: hw/aoc_pkg.sv
// =====================================================================
// converter output and serial control constants
package aoc_pkg;
    // register indices (4-bit serial address)
    localparam logic [3:0]  ADDR_CONFIG      = 4'h1;
    localparam logic [3:0]  ADDR_OFFSET      = 4'h2;
    localparam logic [3:0]  ADDR_FULL_SCALE  = 4'h3;
    localparam logic [3:0]  ADDR_PHASE_FINE  = 4'hD;
    localparam logic [3:0]  ADDR_PHASE_COARSE = 4'hE;
    localparam logic [3:0]  ADDR_PATTERN     = 4'hF;
    // reset values
    localparam logic [15:0] RST_CONFIG       = 16'hB2DF;
    localparam logic [15:0] RST_OFFSET       = 16'h007F;
    localparam logic [15:0] RST_FULL_SCALE   = 16'h807F;
    localparam logic [15:0] RST_PHASE_FINE   = 16'h007F;
    localparam logic [15:0] RST_PHASE_COARSE = 16'h03FF;
    localparam logic [15:0] RST_PATTERN      = 16'hF7FF;
    // configuration field positions
    localparam int          CFG_TRIM_SKIP    = 13;
    localparam int          CFG_DDR_PHASE    = 11;
    localparam int          CFG_DDR_DISABLE  = 10;
    localparam int          CFG_SWING        = 9;
    localparam int          CFG_EDGE_DEMUX   = 8;
    localparam int          PAT_ENABLE       = 11;
    localparam int          COARSE_ENABLE    = 15;
    // serial frame layout
    localparam logic [11:0] FRAME_HEADER     = 12'h001;
    localparam logic [5:0]  FRAME_BITS       = 6'h20;
    // calibration timing in input clocks
    localparam logic [7:0]  CAL_REQ_CYCLES   = 8'h50;
    localparam int          CAL_RUN_CYCLES   = 1024;
endpackage : aoc_pkg

// file: verification/aoc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks for the converter output and serial control
module aoc_top_asserts #(
    parameter int SAMPLE_W = 8
) (
    // clock, reset and pins
    input wire logic                clk_sys,
    input wire logic                rst_b,
    input wire logic                power_down_pin,
    input wire logic                range_or_ext_ctrl_pin,
    input wire logic                double_rate_pin,
    input wire logic [SAMPLE_W-1:0] sample_rise,
    input wire logic [SAMPLE_W-1:0] sample_fall,
    // outputs watched
    input wire logic [SAMPLE_W-1:0] lane_a,
    input wire logic [SAMPLE_W-1:0] lane_b,
    input wire logic [SAMPLE_W-1:0] lane_c,
    input wire logic [SAMPLE_W-1:0] lane_d,
    input wire logic                output_data_clock,
    input wire logic                outputs_oe,
    input wire logic                cal_running,
    input wire logic                auto_phase_en,
    input wire logic [15:0]         offset_word,
    input wire logic [15:0]         full_scale_word
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_pd_tristate;
        (power_down_pin && !cal_running)[*6] |-> !outputs_oe;
    endproperty
    a_pd_tristate: assert property (p_pd_tristate) else $error("outputs on in power down");
    property p_cal_whole;
        $rose(cal_running) |=> cal_running[*8];
    endproperty
    a_cal_whole: assert property (p_cal_whole) else $error("calibration cut short");
    property p_no_cal_pd;
        power_down_pin[*4] |=> !$rose(cal_running);
    endproperty
    a_no_cal_pd: assert property (p_no_cal_pd) else $error("calibration in power down");
    property p_ddr_toggle;
        (!range_or_ext_ctrl_pin && double_rate_pin && outputs_oe && !cal_running)[*5]
            |-> output_data_clock != $past(output_data_clock);
    endproperty
    a_ddr_toggle: assert property (p_ddr_toggle) else $error("double rate clock stuck");
    property p_sdr_steady;
        (!range_or_ext_ctrl_pin && !double_rate_pin && outputs_oe)[*5]
            |-> $stable(output_data_clock);
    endproperty
    a_sdr_steady: assert property (p_sdr_steady) else $error("single rate clock moved");
    property p_phase_mode;
        $stable(range_or_ext_ctrl_pin)[*6] |-> auto_phase_en == !range_or_ext_ctrl_pin;
    endproperty
    a_phase_mode: assert property (p_phase_mode) else $error("phase mode wrong");
    property p_pin_locked;
        !range_or_ext_ctrl_pin |=> $stable(offset_word) && $stable(full_scale_word);
    endproperty
    a_pin_locked: assert property (p_pin_locked) else $error("register changed in pin mode");
    property p_latency;
        !range_or_ext_ctrl_pin && outputs_oe && !cal_running && $past(outputs_oe, 16)
            && !$past(cal_running, 16) |-> lane_d == $past(sample_fall, 14)
            && lane_c == $past(sample_rise, 14) && lane_b == $past(sample_fall, 15)
            && lane_a == $past(sample_rise, 15);
    endproperty
    a_latency: assert property (p_latency) else $error("lane latency wrong");
endmodule // aoc_top_asserts

bind aoc_top aoc_top_asserts #(.SAMPLE_W(SAMPLE_W)) u_asserts (.*);
`default_nettype wire

// file: verification/aoc_serial_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// serial register host; its clock runs only inside frames
module aoc_serial_host (
    // serial register lines
    output logic serial_clk,
    output logic serial_select_n,
    output logic serial_input_line
);
    // idle lines
    initial begin
        serial_clk = 1'b0;
        serial_select_n = 1'b1;
        serial_input_line = 1'b1;
    end
    // shift n bits msb first from the top of bits, 48 ns period
    task automatic send(input logic [63:0] bits, input int n);
        serial_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_input_line = bits[63-i];
            #24 serial_clk = 1'b1;
            #24 serial_clk = 1'b0;
        end
        #24 serial_select_n = 1'b1;
        serial_input_line = ~serial_input_line; // released line shows no stale bit
    endtask
endmodule // aoc_serial_host
`default_nettype wire

// file: verification/aoc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, gt); end end
// ==========================================================
// bench for the converter output and serial control block
module aoc_top_tb_top;
    import aoc_pkg::*;
    logic       clk_sys = 1'b0, rst_b = 1'b0, lane_chk = 1'b0;
    logic [7:0] sample_rise = 8'h00, sample_fall = 8'h00;
    logic       range_rise = 1'b0, range_fall = 1'b0, power_down_pin = 1'b0;
    logic       cal_request_n = 1'b1, range_or_ext_ctrl_pin = 1'b1, launch_edge_select = 1'b1;
    logic       double_rate_pin = 1'b1, swing_select_pin = 1'b1;
    wire logic  serial_clk, serial_select_n, serial_input_line, out_range, output_data_clock;
    wire logic  outputs_oe, cal_running, swing_bit, auto_phase_en;
    wire logic [7:0]  lane_a, lane_b, lane_c, lane_d;
    wire logic [15:0] offset_word, full_scale_word, phase_fine_word, phase_coarse_word;
    int         n_errors = 0, checks_done = 0, seed = 60;
    logic [15:0] ew [16];
    logic [15:0] cfgs [4] = '{16'hB3DF, 16'hB6DF, 16'hB7DF, 16'hB0DF};
    logic [7:0] hr [17], hf [17];

    aoc_top #(.SAMPLE_W(8), .CAL_CYCLES(100)) uut (.*);
    aoc_serial_host host (.*);

    always #2 clk_sys = ~clk_sys;
    // random samples each clock and a history of what was sampled
    always @(posedge clk_sys) begin
        for (int k = 16; k > 0; k--) begin
            hr[k] <= hr[k-1];
            hf[k] <= hf[k-1];
        end
        hr[0] <= sample_rise;
        hf[0] <= sample_fall;
        sample_rise <= 8'($random(seed));
        sample_fall <= 8'($random(seed));
        range_rise <= 1'($random(seed));
        range_fall <= 1'($random(seed));
    end
    // lane model compare, two-lane mode zeroes a and b
    always @(negedge clk_sys) begin
        if (lane_chk && outputs_oe === 1'b1) begin
            `CHK("lane_d", hf[13], lane_d)
            `CHK("lane_c", hr[13], lane_c)
            `CHK("lane_b", (range_or_ext_ctrl_pin && !ew[1][10] && ew[1][8]) ? 8'h00 : hf[14], lane_b)
            `CHK("lane_a", (range_or_ext_ctrl_pin && !ew[1][10] && ew[1][8]) ? 8'h00 : hr[14], lane_a)
        end
    end
    // ==========================================================
    // tasks
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic do_reset(input logic ext);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        range_or_ext_ctrl_pin <= ext;
        repeat (15) @(posedge clk_sys);
        rst_b <= 1'b1;
        ew = '{default: 16'hFFFF};
        ew[1] = RST_CONFIG;
        ew[2] = RST_OFFSET;
        ew[3] = RST_FULL_SCALE;
        ew[13] = RST_PHASE_FINE;
        ew[14] = RST_PHASE_COARSE;
    endtask
    task automatic wait_for(input bit cal, input logic v);
        for (int i = 0; i < 3000 && (cal ? cal_running : outputs_oe) !== v; i++) cyc(1);
        `CHK(cal ? "cal_running" : "outputs_oe", v, cal ? cal_running : outputs_oe)
        if ((cal ? cal_running : outputs_oe) !== v) give_verdict();
    endtask
    task automatic cal_req();
        @(posedge clk_sys);
        cal_request_n <= 1'b0;
        repeat (80) @(posedge clk_sys);
        cal_request_n <= 1'b1;
        repeat (80) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [63:0] bits, input int n);
        logic [31:0] f;
        logic c;
        logic ddr;
        lane_chk = 1'b0;
        host.send(bits, n);
        cyc(10);
        for (int k = 0; k < n / 32; k++) begin
            f = bits[63-32*k -: 32];
            if (f[31:20] == 12'h001 && range_or_ext_ctrl_pin
                && f[19:16] inside {1, 2, 3, 13, 14, 15}) ew[f[19:16]] = f[15:0];
        end
        `CHK("offset_word", ew[2], offset_word)
        `CHK("full_scale_word", ew[3], full_scale_word)
        `CHK("phase_fine_word", ew[13], phase_fine_word)
        `CHK("phase_coarse_word", ew[14], phase_coarse_word)
        `CHK("swing_bit", range_or_ext_ctrl_pin ? ew[1][9] : swing_select_pin, swing_bit)
        ddr = range_or_ext_ctrl_pin ? !ew[1][10] : double_rate_pin;
        cyc(20);
        lane_chk = 1'b1;
        c = output_data_clock;
        cyc(1);
        `CHK("output_data_clock", ddr ? ~c : c, output_data_clock)
    endtask
    // ==========================================================
    // main sequence: extended mode, power scenarios, then pin mode
    initial begin
        do_reset(1'b1);
        wait_for(0, 1'b1);
        `CHK("auto_phase_en", 1'b0, auto_phase_en)
        for (int i = 0; i < 15; i++) if (i != 1) wr({12'h001, 4'(i), 16'($random(seed)), 32'h0}, 32);
        wr({12'h003, ADDR_OFFSET, 16'h5A5A, 32'h0}, 32);
        wr({12'h001, ADDR_OFFSET, 16'hA5A5, 32'h0}, 31);
        wr({12'h001, ADDR_PHASE_FINE, 16'h1357, 12'h001, ADDR_FULL_SCALE, 16'h2468}, 64);
        foreach (cfgs[i]) wr({12'h001, ADDR_CONFIG, cfgs[i], 32'h0}, 32);
        lane_chk = 1'b0;
        @(posedge clk_sys);
        power_down_pin <= 1'b1;
        wait_for(0, 1'b0);
        cal_req();
        cyc(60);
        `CHK("cal_running", 1'b0, cal_running)
        @(posedge clk_sys);
        power_down_pin <= 1'b0;
        wait_for(0, 1'b1);
        `CHK("cal_running", 1'b0, cal_running)
        cal_req();
        wait_for(1, 1'b1);
        @(posedge clk_sys);
        power_down_pin <= 1'b1;
        cyc(4);
        `CHK("cal_running", 1'b1, cal_running)
        wait_for(1, 1'b0);
        cyc(8);
        `CHK("outputs_oe", 1'b0, outputs_oe)
        do_reset(1'b0);
        cyc(100);
        `CHK("cal_running", 1'b0, cal_running)
        @(posedge clk_sys);
        power_down_pin <= 1'b0;
        wait_for(1, 1'b1);
        wait_for(0, 1'b1);
        `CHK("auto_phase_en", 1'b1, auto_phase_en)
        wr({12'h001, ADDR_OFFSET, 16'h0000, 32'h0}, 32);
        @(posedge clk_sys);
        double_rate_pin <= 1'b0;
        cyc(40);
        give_verdict();
    end
endmodule // aoc_top_tb_top
`default_nettype wire
